// ===== logic/dms_pkg.sv
// Package of the diagnostic measurement select block: register map, field
// positions, selector codes, timing counts and carrier types.
// Assumes a 40 MHz control clock and an APB master with 32-bit data.
package dms_pkg;

   // Clock and timing
   localparam int CLK_HZ = 40_000_000;
   localparam int SETTLE_NS = 39_000;
   localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int MON_NS = 1_000_000;
   localparam int MON_CYC = (MON_NS / 1000) * (CLK_HZ / 1_000_000);

   // Sizes
   localparam int NUM_CELLS = 14;
   localparam int RES_W = 14;
   localparam int THR_W = 10;

   // Register byte offsets
   localparam logic [11:0] OFS_DIAG_CFG = 12'h000;
   localparam logic [11:0] OFS_SCAN_CFG = 12'h004;
   localparam logic [11:0] OFS_RESULT_ONE = 12'h008;
   localparam logic [11:0] OFS_RESULT_TWO = 12'h00C;
   localparam logic [11:0] OFS_FAULT_ONE = 12'h010;
   localparam logic [11:0] OFS_FAULT_TWO = 12'h014;
   localparam logic [11:0] OFS_BSW_ALERT = 12'h018;
   localparam logic [11:0] OFS_COV_ALERT = 12'h01C;
   localparam logic [11:0] OFS_OPEN_THR = 12'h020;
   localparam logic [11:0] OFS_TEST_CUR = 12'h024;
   localparam logic [11:0] OFS_BIPOLAR = 12'h028;
   localparam logic [11:0] OFS_TEMP_THR = 12'h02C;

   // Field positions of diagnostic_configuration
   localparam int CFG_SEL1_LSB = 0;
   localparam int CFG_SEL2_LSB = 4;
   localparam int CFG_OPEN_BIT = 8;
   localparam int CFG_TCL_LSB = 9;
   localparam int CFG_CAL_BIT = 12;
   localparam int CFG_W = 13;
   // Result field position, fault status bit positions
   localparam int RES_LSB = 2;
   localparam int FS1_BSW_SUM = 0;
   localparam int FS2_TEMP = 0;
   localparam int FS2_SHDN = 1;

   // Reset values
   localparam logic [CFG_W-1:0] CFG_RST = 13'h0000;
   localparam logic [2:0] SCAN_RST = 3'h0;
   localparam logic [THR_W-1:0] OPEN_THR_RST = 10'h0000;
   localparam logic [RES_W-1:0] TEMP_THR_RST = 14'h3FFF;

   // Diagnostic selector codes
   localparam logic [3:0] SEL_NONE = 4'h0;
   localparam logic [3:0] SEL_DIE_TEMP = 4'h1;
   localparam logic [3:0] SEL_LAST = 4'hC;

   // Scan configuration codes
   localparam logic [2:0] SCAN_COMP = 3'h2;
   localparam logic [2:0] SCAN_BSW_FIRST = 3'h4;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_CONV = 3'b100
   } dms_state_t;

   // ADC answer to a diagnostic conversion
   typedef struct packed {
      logic valid;
      logic [RES_W-1:0] code;
   } dms_adc_t;

   // End of a balancing-switch scan with per-switch fault flags
   typedef struct packed {
      logic done;
      logic [NUM_CELLS-1:0] fault;
   } dms_scan_t;

   // One comparator cell measurement
   typedef struct packed {
      logic strobe;
      logic [3:0] idx;
      logic [THR_W-1:0] code;
   } dms_cell_t;

endpackage

// ===== logic/dms_diag_select.sv
// Diagnostic measurement select: two selector slots, result registers,
// balancing-switch and open-wire alerts, die-temperature monitor, APB slave.
// Assumes analog mux, ADC and comparator engine on the same 40 MHz clock.
`timescale 1ns/1ps

// What this block does
// - Selector 1 converts die temperature; result into bits 15:2 of own slot.
// - Selectors 4, 5, 6 run comparator, gain and offset checks into slot result.
// - Selector 7 runs DAC three-quarter-scale check, expected code 1772.
// - Selector 8 runs DAC one-quarter-scale check, expected code 591.
// - Selector 9 reports thermistor-biased calibration offset error.
// - Selector A does a zero-scale ADC conversion into slot result.
// - Selector B does a full-scale ADC conversion into slot result.
// - Selector C measures level-shift amplifier offset into slot result.
// - Scan configs 4 to 7 fill per-switch alerts and the fault summary bit.
// - Open-wire scan flags each cell measured below the open-wire threshold.
// - Bipolar cells are skipped in open-wire scan, never flagged.
// - Device shuts down when die temperature passes 145 degrees Celsius.
// - Die-temperature conversion waits 39 us from start of measurement cycle.
// - Die temperature checked against alert threshold every 1 ms.
// - Periodic die-temperature monitor pauses while either selector holds 1.
// - Selector 2 converts reference against analog supply into slot result.
// - Selector 3 converts alternate reference against primary reference.
module dms_diag_select #(
   parameter int MON_CYCLES = dms_pkg::MON_CYC,
   parameter logic [dms_pkg::RES_W-1:0] SHDN_CODE = 14'h3000
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic acq_start,
   input wire dms_pkg::dms_adc_t adc_in,
   input wire logic [dms_pkg::RES_W-1:0] die_temp_code,
   input wire dms_pkg::dms_scan_t scan_in,
   input wire dms_pkg::dms_cell_t cell_in,
   output logic conv_req,
   output logic [3:0] conv_sel,
   output logic thermal_shutdown,
   output logic [dms_pkg::NUM_CELLS-1:0] test_current_enable,
   output logic [2:0] test_current_level,
   output logic adc_calibration_enable,
   output logic [2:0] scan_config,
   output logic open_diag_active
);
   import dms_pkg::*;

   localparam int MW = $clog2(MON_CYCLES);

   // Selector codes 1 to C start a conversion; others are ignored
   function automatic logic sel_valid(input logic [3:0] s);
      sel_valid = (s != SEL_NONE) && (s <= SEL_LAST);
   endfunction

   // Register state
   logic [CFG_W-1:0] diag_cfg, next_diag_cfg;
   logic [2:0] next_scan_config;
   logic fs1_sum, next_fs1_sum;
   logic [1:0] fs2, next_fs2;
   logic [NUM_CELLS-1:0] bsw_alert, next_bsw_alert;
   logic [NUM_CELLS-1:0] cov_alert, next_cov_alert;
   logic [THR_W-1:0] open_thr, next_open_thr;
   logic [NUM_CELLS-1:0] next_tce, bipolar, next_bipolar;
   logic [RES_W-1:0] temp_thr, next_temp_thr;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   // Sequencer state
   dms_state_t state, next_state;
   logic slot, next_slot, pend1, next_pend1, pend2, next_pend2;
   logic [3:0] sel1, next_sel1, sel2, next_sel2;
   logic [10:0] elapsed, next_elapsed;
   logic [15:0] result_one, next_result_one, result_two, next_result_two;
   logic next_conv_req;
   logic [3:0] next_conv_sel;
   // Monitor state
   logic [MW-1:0] mon_cnt, next_mon_cnt;
   logic temp_event, next_temp_event, next_shutdown;

   logic access, wr, suspend, settled, cell_hit, bsw_scan;
   logic [3:0] cur_sel;

   assign access = psel && penable && !pready;
   assign wr = access && pwrite;
   assign suspend = (diag_cfg[CFG_SEL1_LSB+:4] == SEL_DIE_TEMP)
                    || (diag_cfg[CFG_SEL2_LSB+:4] == SEL_DIE_TEMP);
   assign settled = (elapsed == 11'(SETTLE_CYC));
   assign cur_sel = slot ? sel2 : sel1;
   // Open-wire hit: comparator scan, select set, below threshold, unipolar only
   assign cell_hit = cell_in.strobe && (scan_config == SCAN_COMP)
                     && diag_cfg[CFG_OPEN_BIT] && (cell_in.idx < 4'(NUM_CELLS))
                     && (cell_in.code < open_thr)
                     && !bipolar[cell_in.idx];
   assign bsw_scan = scan_in.done && (scan_config >= SCAN_BSW_FIRST);

   // Bus answer and register writes; hardware sets win over W1C clears
   always_comb begin
      next_pready = access;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      next_diag_cfg = diag_cfg;
      next_scan_config = scan_config;
      next_open_thr = open_thr;
      next_tce = test_current_enable;
      next_bipolar = bipolar;
      next_temp_thr = temp_thr;
      next_fs1_sum = fs1_sum;
      next_fs2 = fs2;
      next_bsw_alert = bsw_alert;
      next_cov_alert = cov_alert;
      if (access) begin
         case (paddr)
            OFS_DIAG_CFG: begin
               next_prdata = 32'(diag_cfg);
               if (wr) next_diag_cfg = pwdata[CFG_W-1:0];
            end
            OFS_SCAN_CFG: begin
               next_prdata = 32'(scan_config);
               if (wr) next_scan_config = pwdata[2:0];
            end
            OFS_RESULT_ONE: next_prdata = 32'(result_one);
            OFS_RESULT_TWO: next_prdata = 32'(result_two);
            OFS_FAULT_ONE: begin
               next_prdata = 32'(fs1_sum);
               if (wr && pwdata[FS1_BSW_SUM]) next_fs1_sum = 1'b0;
            end
            OFS_FAULT_TWO: begin
               next_prdata = 32'(fs2);
               if (wr) next_fs2 = fs2 & ~pwdata[1:0];
            end
            OFS_BSW_ALERT: begin
               next_prdata = 32'(bsw_alert);
               if (wr) next_bsw_alert = bsw_alert & ~pwdata[NUM_CELLS-1:0];
            end
            OFS_COV_ALERT: begin
               next_prdata = 32'(cov_alert);
               if (wr) next_cov_alert = cov_alert & ~pwdata[NUM_CELLS-1:0];
            end
            OFS_OPEN_THR: begin
               next_prdata = 32'(open_thr);
               if (wr) next_open_thr = pwdata[THR_W-1:0];
            end
            OFS_TEST_CUR: begin
               next_prdata = 32'(test_current_enable);
               if (wr) next_tce = pwdata[NUM_CELLS-1:0];
            end
            OFS_BIPOLAR: begin
               next_prdata = 32'(bipolar);
               if (wr) next_bipolar = pwdata[NUM_CELLS-1:0];
            end
            OFS_TEMP_THR: begin
               next_prdata = 32'(temp_thr);
               if (wr) next_temp_thr = pwdata[RES_W-1:0];
            end
            default: next_pslverr = 1'b1;
         endcase
      end
      // Hardware event sets, applied after clears so a set wins
      if (bsw_scan) begin
         next_bsw_alert = next_bsw_alert | scan_in.fault;
         if (|scan_in.fault) next_fs1_sum = 1'b1;
      end
      if (cell_hit) next_cov_alert[cell_in.idx] = 1'b1;
      if (temp_event) next_fs2[FS2_TEMP] = 1'b1;
      if (thermal_shutdown) next_fs2[FS2_SHDN] = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         diag_cfg <= CFG_RST;
         scan_config <= SCAN_RST;
         open_thr <= OPEN_THR_RST;
         test_current_enable <= '0;
         bipolar <= '0;
         temp_thr <= TEMP_THR_RST;
         fs1_sum <= 1'b0;
         fs2 <= 2'b00;
         bsw_alert <= '0;
         cov_alert <= '0;
         test_current_level <= 3'h0;
         adc_calibration_enable <= 1'b0;
         open_diag_active <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         diag_cfg <= next_diag_cfg;
         scan_config <= next_scan_config;
         open_thr <= next_open_thr;
         test_current_enable <= next_tce;
         bipolar <= next_bipolar;
         temp_thr <= next_temp_thr;
         fs1_sum <= next_fs1_sum;
         fs2 <= next_fs2;
         bsw_alert <= next_bsw_alert;
         cov_alert <= next_cov_alert;
         test_current_level <= next_diag_cfg[CFG_TCL_LSB+:3];
         adc_calibration_enable <= next_diag_cfg[CFG_CAL_BIT];
         open_diag_active <= next_diag_cfg[CFG_OPEN_BIT]
                             && (next_scan_config == SCAN_COMP);
      end
   end

   // Slot sequencer: one conversion per slot holding a code 1 to C per acquisition cycle
   always_comb begin
      next_state = state;
      next_slot = slot;
      next_pend1 = pend1;
      next_pend2 = pend2;
      next_sel1 = sel1;
      next_sel2 = sel2;
      next_result_one = result_one;
      next_result_two = result_two;
      next_conv_req = conv_req;
      next_conv_sel = conv_sel;
      next_elapsed = settled ? elapsed : elapsed + 11'd1;
      if (acq_start) begin
         // New cycle: latch both selectors, restart the settle timer
         next_sel1 = diag_cfg[CFG_SEL1_LSB+:4];
         next_sel2 = diag_cfg[CFG_SEL2_LSB+:4];
         next_pend1 = sel_valid(diag_cfg[CFG_SEL1_LSB+:4]);
         next_pend2 = sel_valid(diag_cfg[CFG_SEL2_LSB+:4]);
         next_elapsed = 11'd0;
         next_conv_req = 1'b0;
         next_state = ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (pend1 || pend2) begin
                  next_slot = !pend1;
                  next_state = ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Die temperature holds off until the settle time is over
               if (cur_sel != SEL_DIE_TEMP || settled) begin
                  next_conv_req = 1'b1;
                  // Code goes to the mux unchanged: 1 temp, 2 supply, 3 alt ref,
                  // 4-6 checks, 7/8 DAC, 9 thermistor, A/B ADC, C amplifier
                  next_conv_sel = cur_sel;
                  next_state = ST_CONV;
               end
            end
            ST_CONV: begin
               if (adc_in.valid) begin
                  next_conv_req = 1'b0;
                  next_state = ST_IDLE;
                  if (slot) begin
                     next_result_two = {adc_in.code, 2'b00};
                     next_pend2 = 1'b0;
                  end else begin
                     next_result_one = {adc_in.code, 2'b00};
                     next_pend1 = 1'b0;
                  end
               end
            end
            default: begin
               next_state = ST_IDLE;
               next_conv_req = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= ST_IDLE;
         slot <= 1'b0;
         pend1 <= 1'b0;
         pend2 <= 1'b0;
         sel1 <= SEL_NONE;
         sel2 <= SEL_NONE;
         elapsed <= 11'(SETTLE_CYC);
         result_one <= 16'h0000;
         result_two <= 16'h0000;
         conv_req <= 1'b0;
         conv_sel <= SEL_NONE;
      end else begin
         state <= next_state;
         slot <= next_slot;
         pend1 <= next_pend1;
         pend2 <= next_pend2;
         sel1 <= next_sel1;
         sel2 <= next_sel2;
         elapsed <= next_elapsed;
         result_one <= next_result_one;
         result_two <= next_result_two;
         conv_req <= next_conv_req;
         conv_sel <= next_conv_sel;
      end
   end

   // 1 ms die-temperature monitor with latched thermal shutdown
   always_comb begin
      next_temp_event = 1'b0;
      next_shutdown = thermal_shutdown;
      next_mon_cnt = mon_cnt + MW'(1);
      if (mon_cnt == MW'(MON_CYCLES - 1)) begin
         next_mon_cnt = '0;
         if (!suspend) begin
            next_temp_event = (die_temp_code > temp_thr);
            if (die_temp_code > SHDN_CODE) next_shutdown = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mon_cnt <= '0;
         temp_event <= 1'b0;
         thermal_shutdown <= 1'b0;
      end else begin
         mon_cnt <= next_mon_cnt;
         temp_event <= next_temp_event;
         thermal_shutdown <= next_shutdown;
      end
   end

endmodule

// ===== tb/dms_diag_select_asserts.sv
// Checker of the diagnostic measurement select block: port-level assertions.
// Assumes it is bound to dms_diag_select, one clock, synchronous nrst.
`timescale 1ns/1ps
module dms_diag_select_asserts #(
   parameter int MON_CYCLES = 40000,
   parameter logic [dms_pkg::RES_W-1:0] SHDN_CODE = 14'h3000
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic acq_start,
   input wire dms_pkg::dms_adc_t adc_in,
   input wire logic [dms_pkg::RES_W-1:0] die_temp_code,
   input wire logic conv_req,
   input wire logic [3:0] conv_sel,
   input wire logic thermal_shutdown,
   input wire logic [2:0] scan_config,
   input wire logic open_diag_active
);
   import dms_pkg::*;
   logic [15:0] since_start;
   logic [15:0] next_since_start;

   // Cycles since the last acquisition start, saturating
   always_comb begin
      next_since_start = since_start;
      if (acq_start)
         next_since_start = 16'h0001;
      else if (since_start != 16'hffff)
         next_since_start = since_start + 16'h0001;
   end
   always_ff @(posedge clk) begin
      if (!nrst)
         since_start <= 16'hffff;
      else
         since_start <= next_since_start;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Bus handshake: one wait state, one-cycle answer
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   property p_apb_wait; s_access |=> s_answer; endproperty
   property p_err_ready; pslverr |-> pready; endproperty
   // Conversion request stands until answered, then drops
   property p_conv_hold;
      conv_req && !adc_in.valid && !acq_start |=> conv_req && $stable(conv_sel);
   endproperty
   property p_conv_done; conv_req && adc_in.valid && !acq_start |=> !conv_req; endproperty
   property p_sel_legal; conv_req |-> conv_sel inside {[4'h1:4'hc]}; endproperty
   property p_temp_settle;
      $rose(conv_req) && conv_sel == SEL_DIE_TEMP |-> since_start >= SETTLE_CYC;
   endproperty
   // Shutdown only from a hot die, and it stays
   property p_shdn_cause; $rose(thermal_shutdown) |-> $past(die_temp_code) > SHDN_CODE; endproperty
   property p_shdn_sticky; thermal_shutdown |=> thermal_shutdown; endproperty
   property p_open_comp; (scan_config != SCAN_COMP) [*2] |-> !open_diag_active; endproperty

   a_apb_wait: assert property (p_apb_wait) else $error("bus answer not after one wait");
   a_err_ready: assert property (p_err_ready) else $error("slave error without ready");
   a_conv_hold: assert property (p_conv_hold) else $error("request dropped early");
   a_conv_done: assert property (p_conv_done) else $error("request held after answer");
   a_sel_legal: assert property (p_sel_legal) else $error("illegal selector on mux");
   a_temp_settle: assert property (p_temp_settle) else $error("die temp too early");
   a_shdn_cause: assert property (p_shdn_cause) else $error("shutdown while cool");
   a_shdn_sticky: assert property (p_shdn_sticky) else $error("shutdown released");
   a_open_comp: assert property (p_open_comp) else $error("open diag off comp scan");
endmodule

bind dms_diag_select dms_diag_select_asserts #(.MON_CYCLES(MON_CYCLES), .SHDN_CODE(SHDN_CODE))
   u_asserts (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .acq_start(acq_start), .adc_in(adc_in), .die_temp_code(die_temp_code),
   .conv_req(conv_req), .conv_sel(conv_sel), .thermal_shutdown(thermal_shutdown),
   .scan_config(scan_config), .open_diag_active(open_diag_active));

// ===== tb/dms_diag_select_test.sv
// Self-checking bench of the diagnostic measurement select block.
// Assumes the checker is bound to the design; short monitor period.
`timescale 1ns/1ps
module dms_diag_select_test;
   import dms_pkg::*;
   localparam int MON = 50;
   logic clk, nrst, psel, penable, pwrite, acq_start, pready, pslverr, err;
   logic conv_req, thermal_shutdown, adc_cal, open_act;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] conv_sel;
   logic [2:0] tcl, scfg;
   logic [NUM_CELLS-1:0] tce;
   logic [RES_W-1:0] die_temp_code;
   dms_adc_t adc_in;
   dms_scan_t scan_in;
   dms_cell_t cell_in;
   int error_cnt, total_checks, n, exp1, exp2, acc, thr, bip, s1, s2, code, f;

   dms_diag_select #(.MON_CYCLES(MON), .SHDN_CODE(14'h3000)) DUT (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acq_start(acq_start), .adc_in(adc_in), .die_temp_code(die_temp_code),
      .scan_in(scan_in), .cell_in(cell_in), .conv_req(conv_req), .conv_sel(conv_sel),
      .thermal_shutdown(thermal_shutdown), .test_current_enable(tce),
      .test_current_level(tcl), .adc_calibration_enable(adc_cal), .scan_config(scfg),
      .open_diag_active(open_act));

   // Clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task tmo;
      error_cnt++;
      $display("Error handshake expected answer seen timeout");
      final_report();
   endtask

   // One bus transfer, held until ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (pready !== 1'b1)
         tmo();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task pulse_acq;
      @(posedge clk) acq_start <= 1'b1;
      @(posedge clk) acq_start <= 1'b0;
   endtask

   // Answer one conversion request with a given code
   task automatic serve(input logic [3:0] sel, input int c, output int waited);
      waited = 0;
      // Step past the edge first: a request that just ended still reads high here
      do begin
         @(posedge clk);
         waited++;
      end while (conv_req !== 1'b1 && waited < 2000);
      if (conv_req !== 1'b1)
         tmo();
      chk("conv_sel", {28'h0, conv_sel}, {28'h0, sel});
      adc_in <= '{valid: 1'b1, code: c[13:0]};
      @(posedge clk) adc_in.valid <= 1'b0;
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'hc00b_77ea));
      {nrst, psel, penable, pwrite, acq_start} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      adc_in = '0;
      scan_in = '0;
      cell_in = '0;
      die_temp_code = 14'h0000;
      {error_cnt, total_checks, exp1, exp2} = {32'h0, 32'h0, 32'h0, 32'h0};
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, OFS_TEMP_THR, 0);
      chk("temp_thr_reset", rd, 32'h0000_3fff);
      apb(1'b1, 12'h030, 32'hffff_ffff);
      chk("unmapped_err", {31'h0, err}, 1);
      apb(1'b1, OFS_RESULT_ONE, 32'hffff_ffff);
      apb(1'b0, OFS_RESULT_ONE, 0);
      chk("result_ro", rd, 0);
      // Every selector code in slot one, random or idle slot two
      for (s1 = 1; s1 <= 12; s1++) begin
         s2 = (s1 % 3 == 0) ? 0 : 1 + $urandom % 12;
         apb(1'b1, OFS_DIAG_CFG, s1 | (s2 << 4));
         pulse_acq();
         code = $urandom % 16384;
         // Supply check answered inside the host's passing window
         if (s1 == 2)
            code = 'h13e4 + $urandom % 'h193;
         serve(s1[3:0], code, n);
         exp1 = code << 2;
         if (s1 == 1)
            chk("settle", {31'h0, n > SETTLE_CYC}, 1);
         if (s2 != 0) begin
            code = $urandom % 16384;
            serve(s2[3:0], code, n);
            exp2 = code << 2;
         end
         apb(1'b0, OFS_RESULT_ONE, 0);
         chk("result_one", rd, exp1);
         if (s1 == 2)
            chk("supply_pass", {31'h0, (rd >> 2) >= 'h13ca && (rd >> 2) <= 'h1592}, 1);
         apb(1'b0, OFS_RESULT_TWO, 0);
         chk("result_two", rd, exp2);
      end
      apb(1'b1, OFS_DIAG_CFG, 0);
      // Balancing-switch scans, code 3 must be ignored
      for (s1 = 3; s1 <= 7; s1++) begin
         apb(1'b1, OFS_BSW_ALERT, 32'h0000_3fff);
         apb(1'b1, OFS_FAULT_ONE, 1);
         apb(1'b1, OFS_SCAN_CFG, s1);
         f = $urandom % 16384;
         acc = (s1 == 3) ? 0 : f;
         @(posedge clk) scan_in <= '{done: 1'b1, fault: f[13:0]};
         @(posedge clk) scan_in.done <= 1'b0;
         apb(1'b0, OFS_BSW_ALERT, 0);
         chk("bsw_alert", rd, acc);
         apb(1'b0, OFS_FAULT_ONE, 0);
         chk("bsw_summary", rd, {31'h0, acc != 0});
      end
      // Open-wire scan with a random bipolar mask
      thr = 512;
      bip = $urandom % 16384;
      apb(1'b1, OFS_OPEN_THR, thr);
      apb(1'b1, OFS_BIPOLAR, bip);
      apb(1'b1, OFS_TEST_CUR, bip ^ 32'h0000_3fff);
      apb(1'b1, OFS_COV_ALERT, 32'h0000_3fff);
      apb(1'b1, OFS_DIAG_CFG, 32'h0000_1f00);
      apb(1'b1, OFS_SCAN_CFG, SCAN_COMP);
      chk("open_active", {31'h0, open_act}, 1);
      chk("scan_out", {29'h0, scfg}, SCAN_COMP);
      chk("test_cur", {18'h0, tce}, bip ^ 32'h0000_3fff);
      chk("test_level", {26'h0, adc_cal, tcl}, 32'h0000_000f);
      acc = 0;
      for (n = 0; n < 14; n++) begin
         code = $urandom % 1024;
         if (code < thr && !bip[n])
            acc |= 1 << n;
         @(posedge clk) cell_in <= '{strobe: 1'b1, idx: n[3:0], code: code[9:0]};
      end
      @(posedge clk) cell_in.strobe <= 1'b0;
      apb(1'b0, OFS_COV_ALERT, 0);
      chk("open_alerts", rd, acc);
      // Die-temperature monitor, held off by selector 1
      apb(1'b1, OFS_SCAN_CFG, 0);
      apb(1'b1, OFS_TEMP_THR, 32'h0000_1000);
      apb(1'b1, OFS_DIAG_CFG, 32'h0000_0011);
      die_temp_code <= 14'h1100;
      repeat (3 * MON) @(posedge clk);
      apb(1'b0, OFS_FAULT_TWO, 0);
      chk("alert_held", rd, 0);
      apb(1'b1, OFS_DIAG_CFG, 0);
      repeat (MON + 4) @(posedge clk);
      apb(1'b0, OFS_FAULT_TWO, 0);
      chk("alert_set", rd, 1);
      die_temp_code <= 14'h0100;
      apb(1'b1, OFS_FAULT_TWO, 1);
      apb(1'b0, OFS_FAULT_TWO, 0);
      chk("alert_clear", rd, 0);
      die_temp_code <= 14'h3001;
      for (n = 0; n < MON + 10 && thermal_shutdown !== 1'b1; n++)
         @(posedge clk);
      chk("shutdown", {31'h0, thermal_shutdown}, 1);
      apb(1'b0, OFS_FAULT_TWO, 0);
      chk("fault_two", rd, 32'h0000_0003);
      // Mid-run reset: shutdown latch and fault flags return to idle
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, OFS_FAULT_TWO, 0);
      chk("fault_two_rst", rd, 0);
      chk("shutdown_rst", {31'h0, thermal_shutdown}, 0);
      final_report();
   end
endmodule
